/* rtl/io_space_consts.svh */
`ifndef IO_SPACE_CONSTS_SVH
`define IO_SPACE_CONSTS_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define RAM_BASE          32'h0000_0000
`define RAM_MAX_LAST      32'h003F_FFFF
`define RAM_FITTED_LAST   32'h0007_FFFF
`define MCU_IO_BASE       32'h1000_0000
`define PLD_A_BASE        32'h2000_0000
`define PLD_B_BASE        32'h3000_0000
`define REGION_MASK       32'hF000_0000
`define MCU_IO_BYTES      32'h0000_0040
`define PLD_A_BYTES       32'h0000_0020
`define PLD_B_BYTES       32'h0000_0040

// ----------------------------------------------------------------------
// Port offsets within the microcontroller I/O area
// ----------------------------------------------------------------------
`define OFS_DATA_PORT     6'h00
`define OFS_CTRL_PORT     6'h04
`define OFS_COUNTER       6'h08
`define OFS_MATCH         6'h0C
`define OFS_SERIAL_DATA   6'h10
`define OFS_SERIAL_STAT   6'h14
`define OFS_IRQ_MAP       6'h18
`define OFS_IRQ_MASK      6'h1C
`define OFS_HALT          6'h20

// ----------------------------------------------------------------------
// Control port fields and reset values
// ----------------------------------------------------------------------
`define CTRL_DIR_BIT      2
`define CTRL_BTN_LO_BIT   6
`define CTRL_BTN_HI_BIT   7
`define CTRL_WR_MASK      8'h37
`define CTRL_RESET        8'h00
`define BYTE_RESET        8'h00
`define IRQ_TIMER_BIT     0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ       200000000
`define TICK_FREQ_HZ      1000
`define TICK_CYCLES       (`CLK_FREQ_HZ / `TICK_FREQ_HZ)

`endif

/* rtl/io_space_pkg.sv */
package io_space_pkg;

   // Region selected by the decoder.
   typedef enum logic [2:0] {
      REGION_NONE,
      REGION_RAM,
      REGION_MCU_IO,
      REGION_PLD_A,
      REGION_PLD_B
   } region_t;

   // Serial transmit sequencer states.
   typedef enum logic [0:0] {
      TX_IDLE,
      TX_WAIT
   } tx_state_t;

   // Complete state of the port bank.
   typedef struct packed {
      logic [7:0]  data_out;
      logic [7:0]  ctrl;
      logic [7:0]  counter;
      logic [7:0]  match;
      logic [7:0]  irq_map;
      logic [7:0]  irq_mask;
      logic [7:0]  serial_stat;
      logic [31:0] tick;
      logic [7:0]  rdata;
      logic        rvalid;
      logic        halt;
      logic        rx_pop;
      logic        tx_push;
      logic [7:0]  tx_data;
      tx_state_t   tx_state;
   } bank_state_t;

endpackage

/* rtl/io_space_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Byte access from the decoder to the port bank.
interface io_space_bus_if;
   logic       sel;
   logic       wr;
   logic [5:0] ofs;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rvalid;

   modport decoder (output sel, output wr, output ofs, output wdata,
                    input rdata, input rvalid);
   modport bank (input sel, input wr, input ofs, input wdata,
                 output rdata, output rvalid);
endinterface

`default_nettype wire

/* rtl/io_port_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "io_space_consts.svh"

// Byte-wide port bank of the microcontroller I/O area.
module io_port_bank
   import io_space_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   io_space_bus_if.bank     bus,
   input  wire logic [7:0]  pins_in,
   input  wire logic [1:0]  buttons_in,
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        rx_ready_in,
   input  wire logic        tx_busy_in,
   output logic      [7:0]  data_out,
   output logic      [7:0]  data_oe_out,
   output logic      [7:0]  ctrl_out,
   output logic             irq_out,
   output logic             halt_out,
   output logic             rx_pop_out,
   output logic             tx_push_out,
   output logic      [7:0]  tx_byte_out
);

   bank_state_t s_q;
   bank_state_t s_d;
   logic        tick_hit;
   logic        dir_in;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   // Decodes byte accesses and advances the counter and status.
   always_comb begin
      s_d         = s_q;
      s_d.rvalid  = 1'b0;
      s_d.halt    = 1'b0;
      s_d.rx_pop  = 1'b0;
      s_d.tx_push = 1'b0;
      dir_in      = s_q.ctrl[`CTRL_DIR_BIT];
      tick_hit    = (s_q.tick == 32'(TICK_CYCLES - 1));
      s_d.tick    = tick_hit ? 32'h0000_0000 : s_q.tick + 32'h0000_0001;
      if (tick_hit) begin
         s_d.counter = s_q.counter + 8'h01;  // Wraps from FF to 00
      end
      // Serial status follows the serial side unless written this cycle.
      s_d.serial_stat = {6'h00, tx_busy_in, rx_ready_in};
      if (bus.sel && bus.wr) begin
         case (bus.ofs)
            `OFS_DATA_PORT: begin
               s_d.data_out = bus.wdata;
            end
            `OFS_CTRL_PORT: begin
               s_d.ctrl = bus.wdata & `CTRL_WR_MASK;
            end
            `OFS_COUNTER: begin
               s_d.counter = bus.wdata;
               s_d.tick    = 32'h0000_0000;
            end
            `OFS_MATCH: begin
               s_d.match = bus.wdata;
            end
            `OFS_SERIAL_DATA: begin
               if (s_q.tx_state == TX_IDLE) begin
                  s_d.tx_data  = bus.wdata;
                  s_d.tx_push  = 1'b1;
                  s_d.tx_state = TX_WAIT;
               end
            end
            `OFS_SERIAL_STAT: begin
               s_d.serial_stat = bus.wdata;
            end
            `OFS_IRQ_MAP: begin
               s_d.irq_map = bus.wdata;
            end
            `OFS_IRQ_MASK: begin
               s_d.irq_mask = bus.wdata;
            end
            `OFS_HALT: begin
               s_d.halt = 1'b1;
            end
            default: begin
               s_d.halt = 1'b0;  // Undefined offsets are ignored
            end
         endcase
      end
      // Counter match raises the timer interrupt bit while its mask bit is set; set wins over clear.
      if (s_q.counter == s_q.match && tick_hit == 1'b0 && s_q.irq_mask[`IRQ_TIMER_BIT]) begin
         s_d.irq_map[`IRQ_TIMER_BIT] = 1'b1;
      end
      if (bus.sel && !bus.wr) begin
         s_d.rvalid = 1'b1;
         case (bus.ofs)
            `OFS_DATA_PORT: begin
               s_d.rdata = dir_in ? pins_in : s_q.data_out;
            end
            `OFS_CTRL_PORT: begin
               s_d.rdata = {buttons_in, s_q.ctrl[5:0]};
            end
            `OFS_COUNTER: begin
               s_d.rdata = s_q.counter;
            end
            `OFS_MATCH: begin
               s_d.rdata = s_q.match;
            end
            `OFS_SERIAL_DATA: begin
               s_d.rdata  = rx_byte_in;
               s_d.rx_pop = rx_ready_in;
            end
            `OFS_IRQ_MAP: begin
               s_d.rdata = s_q.irq_map;
            end
            `OFS_IRQ_MASK: begin
               s_d.rdata = s_q.irq_mask;
            end
            default: begin
               s_d.rdata = `BYTE_RESET;
            end
         endcase
      end
      // Transmitter waits until the push cycle has passed and the serial side is not busy.
      case (s_q.tx_state)
         TX_IDLE: begin
            s_d.tx_state = s_d.tx_state;
         end
         TX_WAIT: begin
            if (!tx_busy_in && !s_q.tx_push) begin
               s_d.tx_state = TX_IDLE;
            end
         end
         default: begin
            s_d.tx_state = TX_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Holds the whole bank state.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_q          <= '0;
         s_q.ctrl     <= `CTRL_RESET;
         s_q.tx_state <= TX_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Port drives all eight lines only while the direction bit is zero.
   assign data_out    = s_q.data_out;
   assign data_oe_out = s_q.ctrl[`CTRL_DIR_BIT] ? 8'h00 : 8'hFF;
   assign ctrl_out    = s_q.ctrl;
   assign irq_out     = |(s_q.irq_map & s_q.irq_mask);
   assign halt_out    = s_q.halt;
   assign rx_pop_out  = s_q.rx_pop;
   assign tx_push_out = s_q.tx_push;
   assign tx_byte_out = s_q.tx_data;
   assign bus.rdata   = s_q.rdata;
   assign bus.rvalid  = s_q.rvalid;

endmodule

`default_nettype wire

/* rtl/io_space_decoder_ports.sv */
`timescale 1ns/1ps
`default_nettype none
`include "io_space_consts.svh"

module io_space_decoder_ports
   import io_space_pkg::*;
#(
   parameter logic [31:0] RAM_LAST     = `RAM_FITTED_LAST,
   parameter int          TICK_CYCLES  = `TICK_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [31:0] addr_in,
   input  wire logic        req_in,
   input  wire logic        wr_in,
   input  wire logic        byte_in,
   input  wire logic [7:0]  wdata_in,
   output logic      [7:0]  rdata_out,
   output logic             rvalid_out,
   output logic             ram_sel_out,
   output logic             pld_a_sel_out,
   output logic             pld_b_sel_out,
   output logic      [6:0]  region_ofs_out,
   output logic             bad_access_out,
   input  wire logic [7:0]  periph_data_line_in,
   output logic      [7:0]  periph_data_line_out,
   output logic      [7:0]  periph_data_line_oe_out,
   output logic      [7:0]  ctrl_port_out,
   input  wire logic [1:0]  buttons_in,
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        rx_ready_in,
   output logic             rx_pop_out,
   input  wire logic        tx_busy_in,
   output logic             tx_push_out,
   output logic      [7:0]  tx_byte_out,
   output logic             irq_out,
   output logic             halt_out
);

   io_space_bus_if bus ();
   region_t        region;

   // ----------------------------------------------------------------------
   // Region decode
   // ----------------------------------------------------------------------
   // Selects one region from the top address nibble and the region size.
   always_comb begin
      region = REGION_NONE;
      case (addr_in & `REGION_MASK)
         `RAM_BASE: begin
            if (addr_in <= RAM_LAST && addr_in <= `RAM_MAX_LAST) begin
               region = REGION_RAM;
            end
         end
         `MCU_IO_BASE: begin
            if ((addr_in - `MCU_IO_BASE) < `MCU_IO_BYTES) begin
               region = REGION_MCU_IO;
            end
         end
         `PLD_A_BASE: begin
            if ((addr_in - `PLD_A_BASE) < `PLD_A_BYTES) begin
               region = REGION_PLD_A;
            end
         end
         `PLD_B_BASE: begin
            if ((addr_in - `PLD_B_BASE) < `PLD_B_BYTES) begin
               region = REGION_PLD_B;
            end
         end
         default: begin
            region = REGION_NONE;  // Unused space
         end
      endcase
   end

   // Same load and store strobes reach memory and I/O alike.
   assign ram_sel_out    = req_in && region == REGION_RAM;
   assign pld_a_sel_out  = req_in && region == REGION_PLD_A;
   assign pld_b_sel_out  = req_in && region == REGION_PLD_B;
   assign region_ofs_out = addr_in[6:0];

   // Controller ports take only byte transfers; others are flagged.
   assign bus.sel        = req_in && region == REGION_MCU_IO && byte_in;
   assign bus.wr         = wr_in;
   assign bus.ofs        = addr_in[5:0];
   assign bus.wdata      = wdata_in;
   assign bad_access_out = req_in && (region == REGION_NONE ||
                           (region == REGION_MCU_IO && !byte_in));

   // ----------------------------------------------------------------------
   // Port bank
   // ----------------------------------------------------------------------
   io_port_bank #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_bank (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .bus         (bus),
      .pins_in     (periph_data_line_in),
      .buttons_in  (buttons_in),
      .rx_byte_in  (rx_byte_in),
      .rx_ready_in (rx_ready_in),
      .tx_busy_in  (tx_busy_in),
      .data_out    (periph_data_line_out),
      .data_oe_out (periph_data_line_oe_out),
      .ctrl_out    (ctrl_port_out),
      .irq_out     (irq_out),
      .halt_out    (halt_out),
      .rx_pop_out  (rx_pop_out),
      .tx_push_out (tx_push_out),
      .tx_byte_out (tx_byte_out)
   );

   // Read answer comes one cycle after the request.
   assign rdata_out  = bus.rdata;
   assign rvalid_out = bus.rvalid;

endmodule

`default_nettype wire

/* verification/io_space_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the decoder and port bank.
module io_space_checker #(
   parameter logic [31:0] RAM_LAST = 32'h0007FFFF
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [31:0] addr_in,
   input  wire logic        req_in,
   input  wire logic        wr_in,
   input  wire logic        byte_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic [7:0]  rdata_out,
   input  wire logic        rvalid_out,
   input  wire logic        ram_sel_out,
   input  wire logic        pld_a_sel_out,
   input  wire logic        pld_b_sel_out,
   input  wire logic        bad_access_out,
   input  wire logic [7:0]  periph_data_line_out,
   input  wire logic [7:0]  periph_data_line_oe_out,
   input  wire logic [7:0]  ctrl_port_out,
   input  wire logic        halt_out
);
   // Byte access that lands in the 64-byte port area.
   logic io_hit;
   assign io_hit = req_in && byte_in && (addr_in[31:6] == 26'h0400000);

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   chk_read_answer: assert property (io_hit && !wr_in |=> rvalid_out)
      else $error("port read not answered");
   chk_no_stray: assert property (!(io_hit && !wr_in) |=> !rvalid_out)
      else $error("answer without byte read");
   chk_ram_select: assert property (ram_sel_out == (req_in && addr_in <= RAM_LAST))
      else $error("ram select wrong");
   chk_pld_select: assert property (pld_b_sel_out == (req_in && addr_in[31:6] == 26'h0C00000))
      else $error("logic region select wrong");
   chk_pld_a_select: assert property (pld_a_sel_out == (req_in && addr_in[31:5] == 27'h1000000))
      else $error("first logic region select wrong");
   chk_word_refused: assert property (req_in && !byte_in && addr_in[31:28] == 4'h1
      |-> bad_access_out)
      else $error("non-byte port access not flagged");
   chk_dir_follows: assert property (periph_data_line_oe_out
      == (ctrl_port_out[2] ? 8'h00 : 8'hFF))
      else $error("direction does not follow control bit");
   chk_data_write: assert property (io_hit && wr_in && addr_in[5:0] == 6'h00
      |=> periph_data_line_out == $past(wdata_in))
      else $error("data port write lost");
   chk_ctrl_write: assert property (io_hit && wr_in && addr_in[5:0] == 6'h04
      |=> ctrl_port_out == ($past(wdata_in) & 8'h37))
      else $error("control write lost");
   chk_halt_pulse: assert property (io_hit && wr_in && addr_in[5:0] == 6'h20
      |=> halt_out ##1 !halt_out)
      else $error("halt not pulsed");
   chk_undef_zero: assert property (io_hit && !wr_in && addr_in[5:0] == 6'h3C
      |=> rdata_out == 8'h00)
      else $error("undefined offset not zero");
endmodule

bind io_space_decoder_ports io_space_checker #(.RAM_LAST(RAM_LAST)) i_io_space_checker (
   .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .req_in(req_in),
   .wr_in(wr_in), .byte_in(byte_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
   .rvalid_out(rvalid_out), .ram_sel_out(ram_sel_out), .pld_a_sel_out(pld_a_sel_out),
   .pld_b_sel_out(pld_b_sel_out),
   .bad_access_out(bad_access_out), .periph_data_line_out(periph_data_line_out),
   .periph_data_line_oe_out(periph_data_line_oe_out), .ctrl_port_out(ctrl_port_out),
   .halt_out(halt_out));

`default_nettype wire

/* verification/cpu_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Processor side issuing single loads and stores.
module cpu_bus_model (
   input  wire logic        clk_in,
   input  wire logic [7:0]  rdata_in,
   output logic      [31:0] addr_out,
   output logic             req_out,
   output logic             wr_out,
   output logic             byte_out,
   output logic      [7:0]  wdata_out
);
   // Bus idles with no request.
   initial begin
      addr_out = 32'h00000000;
      req_out = 1'b0;
      wr_out = 1'b0;
      byte_out = 1'b1;
      wdata_out = 8'h00;
   end

   // An edge passes before each request, so the strobe never toggles twice at once.
   task automatic acc(input logic [31:0] a, input logic w, input logic b,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_in);
      #1;
      addr_out = a;
      wr_out = w;
      byte_out = b;
      wdata_out = d;
      req_out = 1'b1;
      @(posedge clk_in);
      #1;
      req_out = 1'b0;
      q = rdata_in;
   endtask
endmodule

`default_nettype wire

/* verification/tb_io_space_decoder_ports.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_io_space_decoder_ports;
   localparam logic [31:0] IO = 32'h10000000;
   logic        clk_in;
   logic        rstn_in;
   logic [31:0] addr;
   logic        req;
   logic        wr;
   logic        byt;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic [7:0]  q;
   logic [7:0]  pins;
   logic [7:0]  ext;
   logic [7:0]  dout;
   logic [7:0]  oe;
   logic [7:0]  ctrl;
   logic [1:0]  buttons;
   logic [7:0]  rx_byte;
   logic        rx_ready;
   logic        tx_busy;
   logic [7:0]  tx_byte;
   logic [6:0]  ofs;
   logic        rx_pop;
   logic        tx_push;
   logic        irq;
   logic        halt;
   int          n_fail = 0;
   int          cmp_count = 0;

   // The logic devices drive the lines only while the port listens.
   assign pins = (dout & oe) | (ext & ~oe);

   io_space_decoder_ports #(.TICK_CYCLES(4)) i_io_space_decoder_ports (
      .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr), .req_in(req), .wr_in(wr),
      .byte_in(byt), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(),
      .ram_sel_out(), .pld_a_sel_out(), .pld_b_sel_out(), .region_ofs_out(ofs),
      .bad_access_out(), .periph_data_line_in(pins), .periph_data_line_out(dout),
      .periph_data_line_oe_out(oe), .ctrl_port_out(ctrl), .buttons_in(buttons),
      .rx_byte_in(rx_byte), .rx_ready_in(rx_ready), .rx_pop_out(rx_pop),
      .tx_busy_in(tx_busy), .tx_push_out(tx_push), .tx_byte_out(tx_byte), .irq_out(irq),
      .halt_out(halt));

   cpu_bus_model i_cpu_bus_model (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .req_out(req), .wr_out(wr), .byte_out(byt), .wdata_out(wdata));

   // Compares one value and counts the outcome.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic acc(input logic [31:0] a, input logic w, input logic [7:0] d);
      i_cpu_bus_model.acc(a, w, 1'b1, d, q);
   endtask

   // Data port, control port and direction switching.
   task automatic t_ports();
      chk(oe, 8'hFF, "reset direction");
      acc(IO, 1'b1, 8'hA5);
      chk(dout, 8'hA5, "data lines");
      acc(IO, 1'b0, 8'h00);
      chk(q, 8'hA5, "data readback");
      i_cpu_bus_model.acc(IO, 1'b1, 1'b0, 8'h3C, q);
      chk(dout, 8'hA5, "word write refused");
      acc(IO + 32'h4, 1'b1, 8'hFF);
      chk(oe, 8'h00, "input direction");
      acc(IO + 32'h4, 1'b0, 8'h00);
      chk(q, 8'hB7, "control readback");
      ext = 8'h5C;
      acc(IO, 1'b0, 8'h00);
      chk(q, 8'h5C, "pins read");
      acc(IO + 32'h4, 1'b1, 8'h00);
      chk(oe, 8'hFF, "output again");
      $display("test ports done");
   endtask

   // Region edges, undefined offset and halt.
   task automatic t_map();
      acc(32'h0007FFFF, 1'b0, 8'h00);
      acc(32'h00080000, 1'b0, 8'h00);
      acc(32'h3000003F, 1'b0, 8'h00);
      chk({1'b0, ofs}, 8'h3F, "region offset");
      acc(32'h2000001F, 1'b0, 8'h00);
      acc(IO + 32'h3C, 1'b1, 8'hFF);
      acc(IO + 32'h3C, 1'b0, 8'h00);
      chk(q, 8'h00, "undefined offset");
      acc(IO + 32'h20, 1'b1, 8'h00);
      chk({7'h00, halt}, 8'h01, "halt");
      $display("test map done");
   endtask

   // Counter rate, compare interrupt and its mask.
   task automatic t_timer();
      acc(IO + 32'h8, 1'b1, 8'h10);
      repeat (40) @(posedge clk_in);
      acc(IO + 32'h8, 1'b0, 8'h00);
      chk({7'h00, q >= 8'h1A && q <= 8'h1C}, 8'h01, "tick count");
      acc(IO + 32'h1C, 1'b1, 8'h01);
      acc(IO + 32'hC, 1'b1, 8'h05);
      acc(IO + 32'h8, 1'b1, 8'h03);
      for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk_in);
      #1;
      chk({7'h00, irq}, 8'h01, "timer irq");
      acc(IO + 32'h18, 1'b0, 8'h00);
      chk(q & 8'h01, 8'h01, "irq map");
      acc(IO + 32'h1C, 1'b1, 8'h00);
      chk({7'h00, irq}, 8'h00, "irq masked");
      acc(IO + 32'h18, 1'b1, 8'h00);
      acc(IO + 32'h18, 1'b0, 8'h00);
      chk(q, 8'h00, "irq map cleared");
      $display("test timer done");
   endtask

   // Receive read and transmit write share one offset.
   task automatic t_serial();
      rx_byte = 8'h4A;
      rx_ready = 1'b1;
      acc(IO + 32'h10, 1'b0, 8'h00);
      chk(q, 8'h4A, "receive byte");
      chk({7'h00, rx_pop}, 8'h01, "receive pop");
      tx_busy = 1'b1;
      acc(IO + 32'h10, 1'b1, 8'h55);
      chk({7'h00, tx_push}, 8'h01, "transmit push");
      acc(IO + 32'h10, 1'b1, 8'h66);
      chk(tx_byte, 8'h55, "transmit while busy");
      chk({7'h00, tx_push}, 8'h00, "no push while busy");
      tx_busy = 1'b0;
      repeat (3) @(posedge clk_in);
      acc(IO + 32'h10, 1'b1, 8'h77);
      chk(tx_byte, 8'h77, "transmit byte");
      $display("test serial done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Clock at 5 ns period.
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // Reset, then the tests in turn.
   initial begin
      rstn_in = 1'b0;
      ext = 8'h00;
      buttons = 2'b10;
      rx_byte = 8'h00;
      rx_ready = 1'b0;
      tx_busy = 1'b0;
      repeat (20) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      t_ports();
      t_map();
      t_timer();
      t_serial();
      tally_and_finish();
   end

   // Cuts a hang short well beyond the expected run.
   initial begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
endmodule

`default_nettype wire
